// ==== hdl/ch_params.svh ====
// Timing figures and pin widths for the card bus host controller.
// Assumes a single 10 ns system clock; all counts derive from it.
`ifndef CH_PARAMS_SVH
`define CH_PARAMS_SVH

// ==========================================================================
// Clock and conversion
// ==========================================================================
`define CH_CLK_PERIOD_NS 10
// Least time: round up to whole cycles, never below one
`define CH_CYC_UP(ns) \
  ((((ns) + `CH_CLK_PERIOD_NS - 1) / `CH_CLK_PERIOD_NS) > 0 ? \
   (((ns) + `CH_CLK_PERIOD_NS - 1) / `CH_CLK_PERIOD_NS) : 1)
// Longest time: round down, never below one
`define CH_CYC_DN(ns) \
  (((ns) / `CH_CLK_PERIOD_NS) > 0 ? ((ns) / `CH_CLK_PERIOD_NS) : 1)

// ==========================================================================
// Pin widths
// ==========================================================================
`define CH_ADDR_W 11
`define CH_DATA_W 16
`define CH_CNT_W  8

// ==========================================================================
// Strobe widths per mode (250 / 120 / 100 / 80 ns)
// ==========================================================================
`define CH_MEMW_W_M0_NS 150
`define CH_MEMW_W_M1_NS 70
`define CH_MEMW_W_M2_NS 60
`define CH_MEMW_W_M3_NS 55
`define CH_IO_W_M0_NS   165
`define CH_IO_W_M1_NS   70
`define CH_IO_W_M2_NS   65
`define CH_IO_W_M3_NS   55

// ==========================================================================
// Setup ahead of the strobe (address setup dominates enable/select setup)
// ==========================================================================
`define CH_MEM_SU_M0_NS 30
`define CH_MEM_SU_M1_NS 15
`define CH_MEM_SU_M2_NS 10
`define CH_MEM_SU_M3_NS 10
`define CH_IO_SU_M0_NS  70
`define CH_IO_SU_M1_NS  25
`define CH_IO_SU_M2_NS  25
`define CH_IO_SU_M3_NS  15

// ==========================================================================
// Hold after the strobe (largest of address, data, enable hold, recovery)
// ==========================================================================
`define CH_MEM_HD_M0_NS 30
`define CH_MEM_HD_M1_NS 15
`define CH_MEM_HD_M2_NS 15
`define CH_MEM_HD_M3_NS 15
`define CH_IO_HD_M0_NS  30
`define CH_IO_HD_M1_NS  20
`define CH_IO_HD_M2_NS  10
`define CH_IO_HD_M3_NS  10

// ==========================================================================
// Wait line figures
// ==========================================================================
`define CH_WAIT_DELAY_NS 35
`define CH_WAIT_WIDTH_NS 350
`define CH_SYNC_LAT      3

`endif

// ==== hdl/ch_pkg.sv ====
// Types shared by the card bus host controller.
// Assumes ch_params.svh is compiled alongside.
`default_nettype none

package ch_pkg;

  // Kind of bus cycle requested by the user
  typedef enum logic [1:0] {
    CH_KIND_MEMW = 2'h0,
    CH_KIND_IOR  = 2'h1,
    CH_KIND_IOW  = 2'h2
  } ch_kind_t;

  // Cycle-time mode
  typedef enum logic [1:0] {
    CH_MODE_250 = 2'h0,
    CH_MODE_120 = 2'h1,
    CH_MODE_100 = 2'h2,
    CH_MODE_80  = 2'h3
  } ch_mode_t;

  // Controller sequence
  typedef enum logic [1:0] {
    CH_ST_IDLE   = 2'b00,
    CH_ST_SETUP  = 2'b01,
    CH_ST_STROBE = 2'b10,
    CH_ST_HOLD   = 2'b11
  } ch_state_t;

endpackage

`default_nettype wire

// ==== hdl/ch_sync3.sv ====
// Three-stage synchroniser for one asynchronous pin level.
// Assumes the pin may change at any time relative to clk_i.
`default_nettype none

module ch_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // ==========================================================================
  // Shift chain; output follows once stages two and three agree
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg  <= RESET_VAL;
      s2_reg  <= RESET_VAL;
      s3_reg  <= RESET_VAL;
      level_o <= RESET_VAL;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_o <= s3_reg;
    end
  end

endmodule

`default_nettype wire

// ==== hdl/ch_host.sv ====
// Host controller that runs memory write, I/O read and I/O write cycles
// on a removable card's parallel bus, honouring the card's wait line except in the 80 ns mode.
// Assumes the user holds req_* stable while req_valid_i and req_ready_o.
`include "ch_params.svh"
`default_nettype none

module ch_host (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [1:0]            mode_i,
  input  wire logic                  req_valid_i,
  output logic                       req_ready_o,
  input  wire logic [1:0]            req_kind_i,
  input  wire logic [`CH_ADDR_W-1:0] req_addr_i,
  input  wire logic [`CH_DATA_W-1:0] req_wdata_i,
  output logic                       rsp_valid_o,
  output logic [`CH_DATA_W-1:0]      rsp_rdata_o,
  output logic                       rsp_timeout_o,
  output logic                       mem_write_strobe_n_o,
  output logic                       io_read_strobe_n_o,
  output logic                       io_write_strobe_n_o,
  output logic                       register_space_select_n_o,
  output logic [1:0]                 card_enable_pair_n_o,
  output logic [`CH_ADDR_W-1:0]      host_address_bus_o,
  output logic [`CH_DATA_W-1:0]      host_data_bus_o,
  output logic                       host_data_bus_oe_o,
  input  wire logic [`CH_DATA_W-1:0] host_data_bus_i,
  input  wire logic                  cycle_extend_line_n_i
);

  // ==========================================================================
  // Mode table selection
  // ==========================================================================
  function automatic logic [`CH_CNT_W-1:0] pick(
    input logic [1:0] m,
    input int         a,
    input int         b,
    input int         c,
    input int         d
  );
    int v;
    v = (m == 2'h0) ? a : (m == 2'h1) ? b : (m == 2'h2) ? c : d;
    return v[`CH_CNT_W-1:0];
  endfunction

  localparam logic [`CH_CNT_W-1:0] SAMPLE_CYC =
    `CH_CNT_W'(`CH_CYC_UP(`CH_WAIT_DELAY_NS) + `CH_SYNC_LAT);
  localparam logic [`CH_CNT_W-1:0] WAIT_LIMIT =
    `CH_CNT_W'(`CH_CYC_DN(`CH_WAIT_WIDTH_NS) + `CH_SYNC_LAT);

  ch_pkg::ch_state_t     state_reg;
  ch_pkg::ch_kind_t      kind_reg;
  ch_pkg::ch_mode_t      mode_reg;
  logic [`CH_CNT_W-1:0]  cnt_reg;
  logic [`CH_CNT_W-1:0]  wait_cnt_reg;
  logic                  wait_level;

  // Three-stage capture of the asynchronous wait pin
  ch_sync3 #(
    .RESET_VAL (1'b1)
  ) u_wait_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (cycle_extend_line_n_i),
    .level_o (wait_level)
  );

  // Figures for the latched kind and mode
  wire is_io  = (kind_reg != ch_pkg::CH_KIND_MEMW);
  wire is_wr  = (kind_reg != ch_pkg::CH_KIND_IOR);
  wire [1:0] m = mode_reg;
  wire [`CH_CNT_W-1:0] width_cyc = is_io ?
    pick(m, `CH_CYC_UP(`CH_IO_W_M0_NS), `CH_CYC_UP(`CH_IO_W_M1_NS),
         `CH_CYC_UP(`CH_IO_W_M2_NS), `CH_CYC_UP(`CH_IO_W_M3_NS)) :
    pick(m, `CH_CYC_UP(`CH_MEMW_W_M0_NS), `CH_CYC_UP(`CH_MEMW_W_M1_NS),
         `CH_CYC_UP(`CH_MEMW_W_M2_NS), `CH_CYC_UP(`CH_MEMW_W_M3_NS));
  wire [`CH_CNT_W-1:0] setup_cyc = is_io ?
    pick(m, `CH_CYC_UP(`CH_IO_SU_M0_NS), `CH_CYC_UP(`CH_IO_SU_M1_NS),
         `CH_CYC_UP(`CH_IO_SU_M2_NS), `CH_CYC_UP(`CH_IO_SU_M3_NS)) :
    pick(m, `CH_CYC_UP(`CH_MEM_SU_M0_NS), `CH_CYC_UP(`CH_MEM_SU_M1_NS),
         `CH_CYC_UP(`CH_MEM_SU_M2_NS), `CH_CYC_UP(`CH_MEM_SU_M3_NS));
  wire [`CH_CNT_W-1:0] hold_cyc = is_io ?
    pick(m, `CH_CYC_UP(`CH_IO_HD_M0_NS), `CH_CYC_UP(`CH_IO_HD_M1_NS),
         `CH_CYC_UP(`CH_IO_HD_M2_NS), `CH_CYC_UP(`CH_IO_HD_M3_NS)) :
    pick(m, `CH_CYC_UP(`CH_MEM_HD_M0_NS), `CH_CYC_UP(`CH_MEM_HD_M1_NS),
         `CH_CYC_UP(`CH_MEM_HD_M2_NS), `CH_CYC_UP(`CH_MEM_HD_M3_NS));

  // Strobe phase decisions
  wire honor_wait = (mode_reg != ch_pkg::CH_MODE_80);
  wire wait_on    = honor_wait & ~wait_level;
  wire width_met  = (cnt_reg >= width_cyc - `CH_CNT_W'(1));
  wire sample_met = (cnt_reg >= SAMPLE_CYC - `CH_CNT_W'(1));
  wire timeout    = wait_on & (wait_cnt_reg >= WAIT_LIMIT);
  // Strobe stays low while wait holds it, until the wait count reaches WAIT_LIMIT
  wire end_strobe = (width_met & (~honor_wait | (sample_met & ~wait_on)))
                    | timeout;
  wire in_strobe  = (state_reg == ch_pkg::CH_ST_STROBE);
  wire setup_done = (state_reg == ch_pkg::CH_ST_SETUP)
                    & (cnt_reg == setup_cyc - `CH_CNT_W'(1));
  wire hold_done  = (state_reg == ch_pkg::CH_ST_HOLD)
                    & (cnt_reg == hold_cyc - `CH_CNT_W'(1));
  wire take_req   = req_valid_i & req_ready_o;
  wire strobe_end = in_strobe & end_strobe;

  // ==========================================================================
  // Sequence
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= ch_pkg::CH_ST_IDLE;
    else
      unique case (state_reg)
        ch_pkg::CH_ST_IDLE:
          if (take_req)
            state_reg <= ch_pkg::CH_ST_SETUP;
        ch_pkg::CH_ST_SETUP:
          if (setup_done)
            state_reg <= ch_pkg::CH_ST_STROBE;
        ch_pkg::CH_ST_STROBE:
          if (end_strobe)
            state_reg <= ch_pkg::CH_ST_HOLD;
        ch_pkg::CH_ST_HOLD:
          if (hold_done)
            state_reg <= ch_pkg::CH_ST_IDLE;
      endcase
  end

  // Phase counter and wait-duration counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i | take_req | setup_done | strobe_end | hold_done)
      cnt_reg <= '0;
    else if (state_reg != ch_pkg::CH_ST_IDLE)
      cnt_reg <= cnt_reg + `CH_CNT_W'(1);
    if (rst_i | ~in_strobe)
      wait_cnt_reg <= '0;
    else if (wait_on)
      wait_cnt_reg <= wait_cnt_reg + `CH_CNT_W'(1);
  end

  // Request latch; mode is fixed for the whole cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      kind_reg           <= ch_pkg::CH_KIND_MEMW;
      mode_reg           <= ch_pkg::CH_MODE_250;
      host_address_bus_o <= '0;
      host_data_bus_o    <= '0;
    end
    else if (take_req)
    begin
      kind_reg           <= ch_pkg::ch_kind_t'(req_kind_i);
      mode_reg           <= ch_pkg::ch_mode_t'(mode_i);
      host_address_bus_o <= req_addr_i;
      host_data_bus_o    <= req_wdata_i;
    end
  end

  // Enables, select and data drive span setup, strobe and hold
  always_ff @(posedge clk_i)
  begin
    if (rst_i | hold_done)
    begin
      card_enable_pair_n_o      <= 2'h3;
      register_space_select_n_o <= 1'b1;
      host_data_bus_oe_o        <= 1'b0;
    end
    else if (take_req)
    begin
      card_enable_pair_n_o      <= 2'h0;
      register_space_select_n_o <= (req_kind_i == ch_pkg::CH_KIND_MEMW);
      host_data_bus_oe_o        <= (req_kind_i != ch_pkg::CH_KIND_IOR);
    end
  end

  // Strobes fall after setup, rise at end of strobe phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i | strobe_end)
    begin
      mem_write_strobe_n_o <= 1'b1;
      io_read_strobe_n_o   <= 1'b1;
      io_write_strobe_n_o  <= 1'b1;
    end
    else if (setup_done)
    begin
      mem_write_strobe_n_o <= is_io;
      io_read_strobe_n_o   <= is_wr;
      io_write_strobe_n_o  <= ~(is_io & is_wr);
    end
  end

  // Handshake and answer; read data taken as the strobe ends
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_ready_o   <= 1'b0;
      rsp_valid_o   <= 1'b0;
      rsp_rdata_o   <= '0;
      rsp_timeout_o <= 1'b0;
    end
    else
    begin
      req_ready_o <= (state_reg == ch_pkg::CH_ST_IDLE) & ~take_req
                     | hold_done;
      rsp_valid_o <= hold_done;
      if (strobe_end)
      begin
        rsp_rdata_o   <= is_wr ? '0 : host_data_bus_i;
        rsp_timeout_o <= timeout;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [`CH_CNT_W-1:0] low_cnt;
  always_ff @(posedge clk_i)
  begin
    if (rst_i | strobe_end)
      low_cnt <= '0;
    else if (in_strobe)
      low_cnt <= low_cnt + `CH_CNT_W'(1);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_fast_no_wait: assert property (
    (in_strobe && !honor_wait && width_met) |=> mem_write_strobe_n_o
      && io_read_strobe_n_o && io_write_strobe_n_o)
    else $error("strobe stretched in fastest mode");
  chk_wait_bounded: assert property (
    in_strobe |-> wait_cnt_reg <= WAIT_LIMIT)
    else $error("wait held beyond limit without timeout");
  chk_memw_held: assert property (
    (in_strobe && !is_io && wait_on && !timeout) |=> !mem_write_strobe_n_o)
    else $error("memory write strobe raised during wait");
  chk_iow_held: assert property (
    (in_strobe && is_io && is_wr && wait_on && !timeout)
      |=> !io_write_strobe_n_o)
    else $error("io write strobe raised during wait");
  chk_ior_release: assert property (
    (in_strobe && !is_wr && width_met && sample_met && !wait_on)
      |=> io_read_strobe_n_o)
    else $error("io read strobe not ended after wait release");
  chk_io_width: assert property (
    ($rose(io_read_strobe_n_o) || $rose(io_write_strobe_n_o))
      |-> $past(low_cnt) >= width_cyc - `CH_CNT_W'(1))
    else $error("io strobe too short");
  chk_regsel_span: assert property (
    (!io_read_strobe_n_o || !io_write_strobe_n_o
      || $rose(io_read_strobe_n_o) || $rose(io_write_strobe_n_o))
      |-> !register_space_select_n_o && !$past(register_space_select_n_o))
    else $error("register select not spanning io strobe");
  chk_memw_width: assert property (
    $rose(mem_write_strobe_n_o)
      |-> $past(low_cnt) >= width_cyc - `CH_CNT_W'(1))
    else $error("memory write strobe too short");
  chk_mode_stable: assert property (
    (state_reg != ch_pkg::CH_ST_IDLE) |=> $stable(mode_reg))
    else $error("mode changed within a cycle");

endmodule

`default_nettype wire

// ==== verification/ch_card_model.sv ====
// Behavioural card answering the host's bus cycles, with optional wait.
// Assumes the bench sets mode_i, wait_ns_i and rd_value_i per cycle.
`include "ch_params.svh"
`default_nettype none

module ch_card_model #(
  parameter int MAX_WAIT_NS = 350 // Wait width the card reports
) (
  input  wire logic                  mem_write_strobe_n_i,
  input  wire logic                  io_read_strobe_n_i,
  input  wire logic                  io_write_strobe_n_i,
  input  wire logic [`CH_ADDR_W-1:0] host_address_bus_i,
  input  wire logic [`CH_DATA_W-1:0] host_data_bus_i,
  input  wire logic [1:0]            mode_i,
  input  wire logic [15:0]           wait_ns_i,
  input  wire logic [`CH_DATA_W-1:0] rd_value_i,
  output logic                       wait_n_o,
  output logic [`CH_DATA_W-1:0]      rdata_o,
  output logic [`CH_ADDR_W-1:0]      last_addr_o,
  output logic [`CH_DATA_W-1:0]      last_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Strobe decode
  // ==========================================================
  wire logic strobe_n = mem_write_strobe_n_i & io_read_strobe_n_i
                        & io_write_strobe_n_i;
  // No wait at all in the fastest mode
  wire logic stretch = (mode_i != 2'h3) && (wait_ns_i != 16'h0000);

  initial
  begin
    wait_n_o = 1'b1;
    rdata_o = 16'h0000;
  end

  // ==========================================================
  // Cycle answer
  // ==========================================================
  // Wait low within 35 ns, held for the commanded span, data at release
  always @(negedge strobe_n)
  begin
    rdata_o = ~rd_value_i;
    if (stretch)
    begin
      #25 wait_n_o = 1'b0;
      #(wait_ns_i); // At most MAX_WAIT_NS unless a test says so
      if (!io_read_strobe_n_i)
        rdata_o = rd_value_i;
      wait_n_o = 1'b1;
    end
    else
    begin
      #((mode_i == 2'h0) ? 100 : (mode_i == 2'h3) ? 45 : 50);
      if (!io_read_strobe_n_i)
        rdata_o = rd_value_i;
    end
  end

  // Latch write data at strobe end, then stop showing read data
  always @(posedge strobe_n)
  begin
    last_addr_o = host_address_bus_i;
    last_wdata_o = host_data_bus_i;
    rdata_o = ~rdata_o;
  end

endmodule

`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the card bus host controller.
// Assumes ch_host, ch_pkg and the card model are compiled before it.
`include "ch_params.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  clk_i;
  logic                  rst_i;
  logic                  req_valid_i;
  logic                  to_ok;
  logic                  sel_q;
  logic [1:0]            mode_i;
  logic [1:0]            req_kind_i;
  logic [15:0]           wait_ns;
  logic [`CH_ADDR_W-1:0] req_addr_i;
  logic [`CH_DATA_W-1:0] req_wdata_i;
  logic [`CH_DATA_W-1:0] rd_value;
  int                    err_count;
  int                    num_checks;
  int                    width;
  wire logic             req_ready_o, rsp_valid_o, rsp_timeout_o;
  wire logic             mw_n, ir_n, iw_n, sel_n, oe, wait_n;
  wire logic [1:0]       ce_n;
  wire logic [`CH_ADDR_W-1:0] addr, m_addr;
  wire logic [`CH_DATA_W-1:0] rsp_rdata_o, hd_o, card_d, m_wd;
  wire logic [`CH_DATA_W-1:0] bus = oe ? hd_o : card_d;
  wire logic             io_on = !ir_n || !iw_n;

  ch_host ch_host_i (
    .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_kind_i(req_kind_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .rsp_timeout_o(rsp_timeout_o),
    .mem_write_strobe_n_o(mw_n), .io_read_strobe_n_o(ir_n),
    .io_write_strobe_n_o(iw_n), .register_space_select_n_o(sel_n),
    .card_enable_pair_n_o(ce_n), .host_address_bus_o(addr),
    .host_data_bus_o(hd_o), .host_data_bus_oe_o(oe),
    .host_data_bus_i(bus), .cycle_extend_line_n_i(wait_n));

  ch_card_model ch_card_model_i (
    .mem_write_strobe_n_i(mw_n), .io_read_strobe_n_i(ir_n),
    .io_write_strobe_n_i(iw_n), .host_address_bus_i(addr),
    .host_data_bus_i(bus), .mode_i(mode_i), .wait_ns_i(wait_ns),
    .rd_value_i(rd_value), .wait_n_o(wait_n), .rdata_o(card_d),
    .last_addr_o(m_addr), .last_wdata_o(m_wd));

  // ==========================================================
  // Clock, compare and closing
  // ==========================================================
  always #5 clk_i = ~clk_i;

  task automatic chk_eq(input logic [15:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_ge(input int got, lim, input string msg);
    num_checks++;
    if (got < lim)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s got %0d min %0d", $time, msg, got, lim);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic int min_ns(input logic [1:0] md, kd);
    int memw[4] = '{150, 70, 60, 55};
    int io[4] = '{165, 70, 65, 55};
    return (kd == ch_pkg::CH_KIND_MEMW) ? memw[md] : io[md];
  endfunction

  // ==========================================================
  // Pin monitor
  // ==========================================================
  // Count strobe-low cycles; select and enables lead and cover I/O
  always @(posedge clk_i)
  begin
    if (!(mw_n && ir_n && iw_n))
      width = width + 1;
    if (io_on && !rst_i)
      chk_eq({12'h000, sel_q, sel_n, ce_n}, 16'h0000, "select");
    if (!ir_n && !rst_i)
      chk_eq({15'h0000, oe}, 16'h0000, "bus driven on read");
    sel_q = sel_n;
  end

  always @(negedge (mw_n & ir_n & iw_n))
    width = 0;

  // A strobe never ends while the card still waits, except where a timeout is expected (to_ok)
  always @(posedge (mw_n & ir_n & iw_n))
    if (!to_ok)
      chk_eq({15'h0000, wait_n}, 16'h0001, "early end");

  // ==========================================================
  // Shared cycle driver and judge
  // ==========================================================
  task automatic run(input logic [1:0] md, kd, input int wns,
                     output logic [15:0] rd, output logic to);
    int n;
    @(posedge clk_i);
    #1;
    mode_i = md;
    req_kind_i = kd;
    wait_ns = 16'(wns);
    req_addr_i = req_addr_i + 11'h013;
    req_wdata_i = req_wdata_i + 16'h1357;
    rd_value = ~req_wdata_i;
    req_valid_i = 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 50);
    #1 req_valid_i = 1'b0;
    chk_ge(50 - n, 1, "no ready");
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 300);
    chk_ge(300 - n, 1, "no response");
    rd = rsp_rdata_o;
    to = rsp_timeout_o;
  endtask

  task automatic judge(input logic [1:0] md, kd, input int wns,
                       input logic exp_to);
    logic [15:0] rd;
    logic        to;
    run(md, kd, wns, rd, to);
    chk_eq({15'h0000, to}, {15'h0000, exp_to}, "timeout");
    chk_ge(width * 10, min_ns(md, kd), "strobe width");
    chk_eq({5'h00, m_addr}, {5'h00, req_addr_i}, "address");
    if (kd == ch_pkg::CH_KIND_IOR && !exp_to)
      chk_eq(rd, rd_value, "read data");
    else if (kd != ch_pkg::CH_KIND_IOR)
      chk_eq(m_wd, req_wdata_i, "write data");
    if (md != 2'h3 && !exp_to)
      chk_ge(width * 10, 25 + wns, "held under wait");
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset;
    #1;
    chk_eq({12'h000, req_ready_o, mw_n, ir_n, iw_n}, 16'h0007, "reset");
    $display("test reset done");
  endtask

  // Every kind in every mode, back to back, no wait
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 3; k++)
        judge(2'(m), 2'(k), 0, 1'b0);
    $display("test modes done");
  endtask

  // Stretched cycles, including the 350 ns boundary
  task automatic t_waits;
    judge(ch_pkg::CH_MODE_250, ch_pkg::CH_KIND_IOR, 350, 1'b0);
    judge(ch_pkg::CH_MODE_120, ch_pkg::CH_KIND_IOW, 300, 1'b0);
    judge(ch_pkg::CH_MODE_100, ch_pkg::CH_KIND_MEMW, 120, 1'b0);
    judge(ch_pkg::CH_MODE_100, ch_pkg::CH_KIND_IOR, 40, 1'b0);
    $display("test waits done");
  endtask

  // Fastest mode: card never stretches, cycle stays short
  task automatic t_fast_mode;
    judge(ch_pkg::CH_MODE_80, ch_pkg::CH_KIND_IOR, 300, 1'b0);
    chk_ge(200, width * 10, "stretched in fast mode");
    $display("test fast mode done");
  endtask

  // Card holds wait far too long: host gives up and flags it
  task automatic t_timeout;
    int n;
    to_ok = 1'b1;
    judge(ch_pkg::CH_MODE_100, ch_pkg::CH_KIND_IOR, 900, 1'b1);
    n = 0;
    while (wait_n !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    chk_eq({15'h0000, wait_n}, 16'h0001, "wait stuck");
    to_ok = 1'b0;
    judge(ch_pkg::CH_MODE_250, ch_pkg::CH_KIND_IOW, 0, 1'b0);
    $display("test timeout done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    to_ok = 1'b0;
    sel_q = 1'b1;
    mode_i = 2'h0;
    req_kind_i = 2'h0;
    wait_ns = 16'h0000;
    req_addr_i = 11'h000;
    req_wdata_i = 16'h0000;
    rd_value = 16'h0000;
    width = 0;
    repeat (2) @(posedge clk_i);
    t_reset;
    rst_i = 1'b0;
    t_modes;
    t_waits;
    t_fast_mode;
    t_timeout;
    stop_test;
  end

  initial
  begin
    #50000;
    err_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test;
  end

endmodule

`default_nettype wire
